// ===== hdl/ohc_regs_pkg.sv
// Package with register offsets, field positions, reset values and timing
// counts for the list command and status register bank.
// Assumes a plain strobe register port with 32-bit data and byte offsets.
package ohc_regs_pkg;

  // Register byte offsets.
  localparam logic [7:0] OFS_MODE   = 8'h04;
  localparam logic [7:0] OFS_CMD    = 8'h08;
  localparam logic [7:0] OFS_IRQ_ST = 8'h0c;
  localparam logic [7:0] OFS_IRQ_MK = 8'h10;

  // Operating-mode field positions.
  localparam int MODE_RATIO_LO = 0;
  localparam int MODE_PER_EN   = 2;
  localparam int MODE_ISO_EN   = 3;
  localparam int MODE_FS_LO    = 6;

  // Command-and-state field positions.
  localparam int CMD_SRST      = 0;
  localparam int CMD_CTL_PEND  = 1;
  localparam int CMD_BLK_PEND  = 2;
  localparam int CMD_OWN_REQ   = 3;
  localparam int CMD_TALLY_LO  = 16;

  // Interrupt status bit positions.
  localparam int IRQ_OVERRUN   = 0;
  localparam int IRQ_SRST_DONE = 1;
  localparam int IRQ_W         = 2;

  // Functional state encodings.
  localparam logic [1:0] FS_RESET   = 2'h0;
  localparam logic [1:0] FS_RESUME  = 2'h1;
  localparam logic [1:0] FS_OPER    = 2'h2;
  localparam logic [1:0] FS_SUSPEND = 2'h3;

  // Reset values.
  localparam logic [1:0] RATIO_RST  = 2'h0;
  localparam logic [1:0] TALLY_RST  = 2'h0;

  // Software reset lasts this long, in ns, and in clock cycles at 4 ns.
  localparam int SRST_TIME_NS  = 40;
  localparam int CLK_PERIOD_NS = 4;
  localparam int SRST_CYCLES   = (SRST_TIME_NS + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;

  // Frame-level list enables handed to the traversal engine.
  typedef struct packed {
    logic       iso_en;
    logic       per_en;
    logic [1:0] ratio;
  } frame_ctl_t;

  // Register port request.
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } reg_req_t;

endpackage : ohc_regs_pkg

// ===== hdl/ohc_ratio_sel.sv
// Control/bulk arbiter picking which list is served next within a frame.
// Assumes the traversal engine pulses served strobes once per descriptor.
`timescale 1ns/1ps
`default_nettype none

module ohc_ratio_sel #(
  parameter int RATIO_W = 2
) (
  // Clock and reset.
  input  wire logic               clk_i,
  input  wire logic               srst_i,
  // Ratio and service strobes.
  input  wire logic [RATIO_W-1:0] ratio_i,
  input  wire logic               frame_start_i,
  input  wire logic               ctl_served_i,
  input  wire logic               blk_served_i,
  // Selection.
  output logic                    pick_bulk_o
);

  logic [RATIO_W:0] cnt_ff;
  logic [RATIO_W:0] nxt_cnt;

  // Counts control descriptors; bulk is due after ratio+1 of them.
  always_comb begin
    nxt_cnt = cnt_ff;
    if (frame_start_i || blk_served_i) begin
      nxt_cnt = '0;
    end else if (ctl_served_i && !pick_bulk_o) begin
      nxt_cnt = cnt_ff + (RATIO_W+1)'(1);
    end
  end

  // Registers the control count.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  // Bulk is picked once n+1 control descriptors were served.
  assign pick_bulk_o = (cnt_ff > {1'b0, ratio_i});

endmodule : ohc_ratio_sel

`default_nettype wire

// ===== hdl/ohc_list_cmd.sv
// Operating-mode low fields and command-and-state register with interrupt.
// Assumes the traversal engine supplies frame, overrun and list-start events.
`timescale 1ns/1ps
`default_nettype none

module ohc_list_cmd #(
  parameter int SRST_LEN = ohc_regs_pkg::SRST_CYCLES
) (
  // Clock and reset.
  input  wire logic        clk_i,
  input  wire logic        srst_i,
  // Register port.
  input  wire logic [7:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic [31:0]      rdata_o,
  // Traversal engine events and pointers.
  input  wire logic        frame_start_i,
  input  wire logic        overrun_i,
  input  wire logic        ctl_start_i,
  input  wire logic        blk_start_i,
  input  wire logic        ctl_served_i,
  input  wire logic        blk_served_i,
  input  wire logic [31:0] head_control_pointer_i,
  input  wire logic [31:0] current_bulk_pointer_i,
  // Engine controls.
  output logic             iso_active_o,
  output logic             per_active_o,
  output logic             ctl_may_start_o,
  output logic             blk_may_start_o,
  output logic             pick_bulk_o,
  output logic             soft_reset_o,
  output logic [1:0]       functional_state_o,
  // Interrupt.
  output logic             irq_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Register state.

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_SRST = 2'b10
  } srst_st_t;

  ohc_regs_pkg::frame_ctl_t mode_ff, nxt_mode;
  ohc_regs_pkg::frame_ctl_t act_ff, nxt_act;
  logic [1:0]               fs_ff, nxt_fs;
  logic                     own_ff, nxt_own;
  logic                     blkp_ff, nxt_blkp;
  logic                     ctlp_ff, nxt_ctlp;
  logic [1:0]               tally_ff, nxt_tally;
  logic [ohc_regs_pkg::IRQ_W-1:0] ist_ff, nxt_ist;
  logic [ohc_regs_pkg::IRQ_W-1:0] imk_ff, nxt_imk;
  srst_st_t                 st_ff, nxt_st;
  logic [7:0]               scnt_ff, nxt_scnt;
  logic [31:0]              rdata_ff, nxt_rdata;

  logic wr_mode;
  logic wr_cmd;
  logic wr_mk;
  logic rd_st;
  logic in_srst;

  // Address decode for write and read strobes.
  assign wr_mode = wr_i && (addr_i == ohc_regs_pkg::OFS_MODE);
  assign wr_cmd  = wr_i && (addr_i == ohc_regs_pkg::OFS_CMD);
  assign wr_mk   = wr_i && (addr_i == ohc_regs_pkg::OFS_IRQ_MK);
  assign rd_st   = rd_i && (addr_i == ohc_regs_pkg::OFS_IRQ_ST);
  assign in_srst = (st_ff == ST_SRST);

  ////////////////////////////////////////////////////////////////////////////
  // Software reset sequencer.

  // Starts on a written one, holds for the reset length, then idles.
  always_comb begin
    nxt_st   = st_ff;
    nxt_scnt = scnt_ff;
    unique case (st_ff)
      ST_IDLE: begin
        if (wr_cmd && wdata_i[ohc_regs_pkg::CMD_SRST]) begin
          nxt_st   = ST_SRST;
          nxt_scnt = 8'(SRST_LEN - 1);
        end
      end
      ST_SRST: begin
        if (scnt_ff == 8'h00) begin
          nxt_st = ST_IDLE;
        end else begin
          nxt_scnt = scnt_ff - 8'h01;
        end
      end
      default: begin
        nxt_st   = ST_IDLE;
        nxt_scnt = 8'h00;
      end
    endcase
  end

  // Registers the sequencer.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      st_ff   <= ST_IDLE;
      scnt_ff <= 8'h00;
    end else begin
      st_ff   <= nxt_st;
      scnt_ff <= nxt_scnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode, command and status registers.

  // Computes next values of software-visible state.
  always_comb begin
    nxt_mode  = mode_ff;
    nxt_act   = act_ff;
    nxt_fs    = fs_ff;
    nxt_own   = own_ff;
    nxt_blkp  = blkp_ff;
    nxt_ctlp  = ctlp_ff;
    nxt_tally = tally_ff;
    nxt_ist   = ist_ff;
    nxt_imk   = imk_ff;
    if (wr_mode) begin
      nxt_mode.iso_en = wdata_i[ohc_regs_pkg::MODE_ISO_EN];
      nxt_mode.per_en = wdata_i[ohc_regs_pkg::MODE_PER_EN];
      nxt_mode.ratio  = wdata_i[ohc_regs_pkg::MODE_RATIO_LO +: 2];
      nxt_fs          = wdata_i[ohc_regs_pkg::MODE_FS_LO +: 2];
    end
    // Enables reach the engine only at a frame boundary or when soft reset clears them.
    if (frame_start_i) begin
      nxt_act.iso_en = mode_ff.iso_en;
      nxt_act.per_en = mode_ff.per_en;
    end
    nxt_act.ratio = mode_ff.ratio;
    // Command bits: writes store, soft reset bit only via sequencer.
    if (wr_cmd) begin
      nxt_own  = wdata_i[ohc_regs_pkg::CMD_OWN_REQ];
      nxt_blkp = wdata_i[ohc_regs_pkg::CMD_BLK_PEND];
      nxt_ctlp = wdata_i[ohc_regs_pkg::CMD_CTL_PEND];
    end
    // Starting a list consumes its pending flag.
    if (blk_start_i && blk_may_start_o && blkp_ff) begin
      nxt_blkp = 1'b0;
    end
    if (ctl_start_i && ctl_may_start_o && ctlp_ff) begin
      nxt_ctlp = 1'b0;
    end
    // Read of status clears it; new events win over the clear.
    if (rd_st) begin
      nxt_ist = '0;
    end
    if (wr_mk) begin
      nxt_imk = wdata_i[ohc_regs_pkg::IRQ_W-1:0];
    end
    if (overrun_i) begin
      nxt_tally = tally_ff + 2'h1;
      nxt_ist[ohc_regs_pkg::IRQ_OVERRUN] = 1'b1;
    end
    // Soft reset clears most registers and parks in suspend.
    if (in_srst) begin
      nxt_mode  = '0;
      nxt_act   = '0;
      nxt_own   = 1'b0;
      nxt_blkp  = 1'b0;
      nxt_ctlp  = 1'b0;
      nxt_tally = ohc_regs_pkg::TALLY_RST;
      nxt_fs    = ohc_regs_pkg::FS_SUSPEND;
      if (scnt_ff == 8'h00) begin
        nxt_ist[ohc_regs_pkg::IRQ_SRST_DONE] = 1'b1;
      end
    end
  end

  // Registers software-visible state.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      mode_ff  <= '0;
      act_ff   <= '0;
      fs_ff    <= ohc_regs_pkg::FS_RESET;
      own_ff   <= 1'b0;
      blkp_ff  <= 1'b0;
      ctlp_ff  <= 1'b0;
      tally_ff <= ohc_regs_pkg::TALLY_RST;
      ist_ff   <= '0;
      imk_ff   <= '0;
    end else begin
      mode_ff  <= nxt_mode;
      act_ff   <= nxt_act;
      fs_ff    <= nxt_fs;
      own_ff   <= nxt_own;
      blkp_ff  <= nxt_blkp;
      ctlp_ff  <= nxt_ctlp;
      tally_ff <= nxt_tally;
      ist_ff   <= nxt_ist;
      imk_ff   <= nxt_imk;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data.

  // Builds read data; reserved and unmapped bits read zero.
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    if (rd_i) begin
      unique case (addr_i)
        ohc_regs_pkg::OFS_MODE: begin
          nxt_rdata[ohc_regs_pkg::MODE_RATIO_LO +: 2] = mode_ff.ratio;
          nxt_rdata[ohc_regs_pkg::MODE_PER_EN]        = mode_ff.per_en;
          nxt_rdata[ohc_regs_pkg::MODE_ISO_EN]        = mode_ff.iso_en;
          nxt_rdata[ohc_regs_pkg::MODE_FS_LO +: 2]    = fs_ff;
        end
        ohc_regs_pkg::OFS_CMD: begin
          nxt_rdata[ohc_regs_pkg::CMD_SRST]      = in_srst;
          nxt_rdata[ohc_regs_pkg::CMD_CTL_PEND]  = ctlp_ff;
          nxt_rdata[ohc_regs_pkg::CMD_BLK_PEND]  = blkp_ff;
          nxt_rdata[ohc_regs_pkg::CMD_OWN_REQ]   = own_ff;
          nxt_rdata[ohc_regs_pkg::CMD_TALLY_LO +: 2] = tally_ff;
        end
        ohc_regs_pkg::OFS_IRQ_ST: begin
          nxt_rdata[ohc_regs_pkg::IRQ_W-1:0] = ist_ff;
        end
        ohc_regs_pkg::OFS_IRQ_MK: begin
          nxt_rdata[ohc_regs_pkg::IRQ_W-1:0] = imk_ff;
        end
        default: begin
          nxt_rdata = 32'h0000_0000;
        end
      endcase
    end
  end

  // Registers read data for the following cycle.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rdata_ff <= 32'h0000_0000;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs to the engine.

  // Control/bulk service ratio arbiter.
  ohc_ratio_sel #(
    .RATIO_W (2)
  ) u_ratio (
    .clk_i         (clk_i),
    .srst_i        (srst_i),
    .ratio_i       (act_ff.ratio),
    .frame_start_i (frame_start_i),
    .ctl_served_i  (ctl_served_i),
    .blk_served_i  (blk_served_i),
    .pick_bulk_o   (pick_bulk_o)
  );

  // List start permission with zero pointer needs the pending flag.
  assign blk_may_start_o = !in_srst &&
    ((current_bulk_pointer_i != 32'h0000_0000) || blkp_ff);
  assign ctl_may_start_o = !in_srst &&
    ((head_control_pointer_i != 32'h0000_0000) || ctlp_ff);

  // Root hub and bus reset are driven only by the functional state field.
  assign functional_state_o = fs_ff;
  assign soft_reset_o       = in_srst;
  assign iso_active_o       = act_ff.iso_en && act_ff.per_en;
  assign per_active_o       = act_ff.per_en;
  assign rdata_o            = rdata_ff;
  assign irq_o              = |(ist_ff & imk_ff);

endmodule : ohc_list_cmd

`default_nettype wire

// ===== tb/ohc_list_cmd_chk.sv
// Port checker for the list command and status register bank.
// Assumes it is bound into ohc_list_cmd and shares its clock and reset.
`timescale 1ns/1ps
`default_nettype none

module ohc_list_cmd_chk #(
  parameter int SRST_LEN = 2
) (
  // Clock, reset and register port.
  input wire logic        clk_i,
  input wire logic        srst_i,
  input wire logic [7:0]  addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [31:0] rdata_o,
  // Engine side.
  input wire logic        frame_start_i,
  input wire logic        ctl_start_i,
  input wire logic        blk_start_i,
  input wire logic [31:0] head_control_pointer_i,
  input wire logic [31:0] current_bulk_pointer_i,
  input wire logic        per_active_o,
  input wire logic        ctl_may_start_o,
  input wire logic        blk_may_start_o,
  input wire logic        soft_reset_o,
  input wire logic [1:0]  functional_state_o
);
  localparam logic [7:0] CMD = ohc_regs_pkg::OFS_CMD;
  logic [7:0] run_ff;
  logic [7:0] nxt_run;

  // Counts how long the soft reset has been in progress.
  always_comb nxt_run = soft_reset_o ? run_ff + 8'h1 : 8'h0;
  always_ff @(posedge clk_i) run_ff <= srst_i ? 8'h0 : nxt_run;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  ////////////////////////////////////////////////////////////////////////////
  sequence s_srst_wr;
    wr_i && addr_i == CMD && wdata_i[0];
  endsequence
  sequence s_srst_end;
    $fell(soft_reset_o);
  endsequence
  sequence s_blk_go;
    blk_start_i && blk_may_start_o && !wr_i;
  endsequence
  sequence s_ctl_go;
    ctl_start_i && ctl_may_start_o && !wr_i;
  endsequence

  property p_srst_go;
    s_srst_wr |=> soft_reset_o;
  endproperty
  property p_srst_zero;
    wr_i && addr_i == CMD && !wdata_i[0] && !soft_reset_o |=> !soft_reset_o;
  endproperty
  property p_srst_len;
    s_srst_end |-> run_ff == 8'(SRST_LEN);
  endproperty
  property p_srst_fs;
    s_srst_end |-> functional_state_o == ohc_regs_pkg::FS_SUSPEND;
  endproperty
  property p_rsvd;
    $past(rd_i) && $past(addr_i) == CMD |->
      rdata_o[31:18] == 14'h0 && rdata_o[15:4] == 12'h0;
  endproperty
  property p_per_frame;
    per_active_o != $past(per_active_o) |->
      $past(frame_start_i) || $past(soft_reset_o) || soft_reset_o;
  endproperty
  property p_blk_clr;
    s_blk_go ##1 current_bulk_pointer_i == 32'h0 |-> !blk_may_start_o;
  endproperty
  property p_ctl_clr;
    s_ctl_go ##1 head_control_pointer_i == 32'h0 |-> !ctl_may_start_o;
  endproperty
  property p_ctl_ptr;
    head_control_pointer_i != 32'h0 && !soft_reset_o |-> ctl_may_start_o;
  endproperty

  a_srst_go: assert property (p_srst_go)
    else $error("soft reset did not start");
  a_srst_zero: assert property (p_srst_zero)
    else $error("zero write started soft reset");
  a_srst_len: assert property (p_srst_len)
    else $error("soft reset length wrong");
  a_srst_fs: assert property (p_srst_fs)
    else $error("not suspend after soft reset");
  a_rsvd: assert property (p_rsvd)
    else $error("reserved command bits set");
  a_per_frame: assert property (p_per_frame)
    else $error("periodic enable moved off frame");
  a_blk_clr: assert property (p_blk_clr)
    else $error("bulk pending not cleared");
  a_ctl_clr: assert property (p_ctl_clr)
    else $error("control pending not cleared");
  a_ctl_ptr: assert property (p_ctl_ptr)
    else $error("control start blocked");
endmodule : ohc_list_cmd_chk

bind ohc_list_cmd ohc_list_cmd_chk #(.SRST_LEN(SRST_LEN)) u_chk (
  .clk_i(clk_i), .srst_i(srst_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .frame_start_i(frame_start_i), .ctl_start_i(ctl_start_i),
  .blk_start_i(blk_start_i), .per_active_o(per_active_o),
  .head_control_pointer_i(head_control_pointer_i),
  .current_bulk_pointer_i(current_bulk_pointer_i),
  .ctl_may_start_o(ctl_may_start_o), .blk_may_start_o(blk_may_start_o),
  .soft_reset_o(soft_reset_o), .functional_state_o(functional_state_o));

`default_nettype wire

// ===== tb/tb.sv
// Self-checking bench for the list command and status register bank.
// Assumes the package, design and bound checker are compiled before it.
`timescale 1ns/1ps
`default_nettype none

module tb;
  localparam logic [7:0] MD = ohc_regs_pkg::OFS_MODE;
  localparam logic [7:0] CM = ohc_regs_pkg::OFS_CMD;
  localparam logic [7:0] IS = ohc_regs_pkg::OFS_IRQ_ST;
  localparam logic [7:0] IM = ohc_regs_pkg::OFS_IRQ_MK;
  logic        clk_i = 1'b0;
  logic        srst_i = 1'b1;
  logic [7:0]  addr_i = 8'h0;
  logic [31:0] wdata_i = 32'h0;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  logic        rd_q = 1'b0;
  logic [5:0]  ev = 6'h0;
  logic [31:0] hcp = 32'h0;
  logic [31:0] cbp = 32'h0;
  logic [31:0] rdata_o;
  logic        iso_o, per_o, cms_o, bms_o, pick_o, srst_o, irq_o;
  logic [1:0]  fs_o;
  logic [31:0] expq[$];
  int          fail_count = 0;
  int          num_checks = 0;

  ohc_list_cmd #(.SRST_LEN(2)) dut (
    .clk_i(clk_i), .srst_i(srst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .frame_start_i(ev[0]),
    .overrun_i(ev[1]), .ctl_start_i(ev[2]), .blk_start_i(ev[3]),
    .ctl_served_i(ev[4]), .blk_served_i(ev[5]),
    .head_control_pointer_i(hcp), .current_bulk_pointer_i(cbp),
    .iso_active_o(iso_o), .per_active_o(per_o), .ctl_may_start_o(cms_o),
    .blk_may_start_o(bms_o), .pick_bulk_o(pick_o), .soft_reset_o(srst_o),
    .functional_state_o(fs_o), .irq_o(irq_o));

  // Free-running 250 MHz clock.
  initial forever #2 clk_i = ~clk_i;

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : tally_and_finish

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
    @(posedge clk_i);
  endtask : wr

  // A read notes its expectation; the watcher below compares the answer.
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    expq.push_back(e);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    @(posedge clk_i);
  endtask : rd

  task automatic pulse(input int i);
    ev[i] <= 1'b1;
    @(posedge clk_i);
    ev[i] <= 1'b0;
    @(posedge clk_i);
  endtask : pulse

  // Takes the oldest note whenever read data stand on the port.
  always @(posedge clk_i) begin
    if (rd_q) chk(rdata_o, expq.pop_front());
    rd_q <= rd_i;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    int n;
    int t;
    void'($urandom(32'h02ef));
    repeat (10) @(posedge clk_i);
    srst_i <= 1'b0;
    @(posedge clk_i);
    rd(MD, 32'h0);
    rd(CM, 32'h0);
    rd(IS, 32'h0);
    chk(32'(fs_o), 32'h0);
    // Zero pointers need the pending flags; a start clears them.
    chk({30'h0, cms_o, bms_o}, 32'h0);
    wr(CM, 32'h6);
    chk({30'h0, cms_o, bms_o}, 32'h3);
    pulse(2);
    rd(CM, 32'h4);
    pulse(3);
    rd(CM, 32'h0);
    chk({30'h0, cms_o, bms_o}, 32'h0);
    hcp <= $urandom | 32'h1;
    cbp <= $urandom | 32'h1;
    @(posedge clk_i);
    chk({30'h0, cms_o, bms_o}, 32'h3);
    // Each ratio lets n+1 control descriptors pass before a bulk one.
    for (n = 0; n < 4; n++) begin
      wr(MD, 32'hc | n);
      if (n == 0) chk({30'h0, iso_o, per_o}, 32'h0);
      pulse(0);
      chk({30'h0, iso_o, per_o}, 32'h3);
      rd(MD, 32'hc | n);
      repeat (n + 1) begin
        chk(32'(pick_o), 32'h0);
        pulse(4);
      end
      chk(32'(pick_o), 32'h1);
      pulse(5);
    end
    wr(MD, 32'h0);
    chk({30'h0, iso_o, per_o}, 32'h3);
    pulse(0);
    chk({30'h0, iso_o, per_o}, 32'h0);
    // Overruns bump the tally and a sticky, maskable status bit.
    wr(IM, 32'h1);
    for (n = 1; n < 6; n++) begin
      pulse(1);
      rd(CM, (n % 4) << 16);
    end
    chk(32'(irq_o), 32'h1);
    rd(IS, 32'h1);
    @(posedge clk_i);
    chk(32'(irq_o), 32'h0);
    wr(CM, 32'h3_0000);
    rd(CM, 32'h1_0000);
    wr(IM, 32'h0);
    pulse(1);
    chk(32'(irq_o), 32'h0);
    wr(IM, 32'h3);
    chk(32'(irq_o), 32'h1);
    rd(IS, 32'h1);
    wr(CM, 32'h8);
    chk(32'(irq_o), 32'h0);
    rd(CM, 32'h2_0008);
    // Soft reset: zero write is idle, one write resets into suspend.
    wr(MD, 32'h87);
    chk(32'(fs_o), 32'h2);
    rd(MD, 32'h87);
    wr(CM, 32'h0);
    chk(32'(srst_o), 32'h0);
    wr(CM, 32'h1);
    t = 0;
    while (srst_o === 1'b1 && t < 50) begin
      t++;
      @(posedge clk_i);
    end
    // A timeout counts as a mismatch and skips to the report.
    if (t == 50) begin
      fail_count++;
    end else begin
      chk(32'(t), 32'h2);
      chk(32'(fs_o), 32'h3);
      rd(CM, 32'h0);
      rd(MD, 32'hc0);
      rd(IS, 32'h2);
    end
    // Lets the watcher take the last read before the verdict.
    @(posedge clk_i);
    tally_and_finish();
  end
endmodule : tb

`default_nettype wire
